// ==== verilog/cmg_consts.vh ====
// constants for the configuration mode and global control block
`ifndef CMG_CONSTS_VH
`define CMG_CONSTS_VH
`define CMG_MODE_MASTER_SERIAL 3'h0
`define CMG_MODE_SERIAL_FLASH  3'h1
`define CMG_MODE_PAR_UP        3'h2
`define CMG_MODE_PAR_DOWN      3'h3
`define CMG_MODE_SCAN          3'h5
`define CMG_MODE_ILLEGAL       3'h4
`define CMG_MODE_SLAVE_PAR     3'h6
`define CMG_MODE_SLAVE_SERIAL  3'h7
`define CMG_ST_IDLE            3'h0
`define CMG_ST_INIT            3'h1
`define CMG_ST_LOAD            3'h2
`define CMG_ST_STARTUP         3'h3
`define CMG_ST_DONE            3'h4
`define CMG_INIT_CYCLES        8'h10
`define CMG_CCLK_DIV           4'h4
`define CMG_STARTUP_STEPS      3'h4
`define CMG_MODE_W             3
`endif

// ==== verilog/cmg_sync2.v ====
// two-flop synchroniser for one pin input
`timescale 1ns/1ps
module cmg_sync2
(
    input  wire clk_sys,
    input  wire reset,
    input  wire clk_en,
    input  wire pin_in,
    output wire sync_out
);
    reg meta_q;
    reg sync_q;

    // first flop is read only by the second
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else if (clk_en)
        begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// ==== verilog/cmg_config_ctrl.v ====
// configuration mode selection, loader sequencing and global controls
//
// Functional notes
// - global_initialize high forces initial state
// - global_initialize held during whole configuration
// - global_output_float high floats all I/O
// - mode pins sampled when init status rises
// - mode pins freed as user I/O afterwards
// - borrowed pins return to user I/O
// - self-loading modes drive clock, read memory
// - daisy chain passes data downstream
// - alternate start-up clock input provided
// - mode decode table of eight codes
// - pull-up select low enables pull-ups until configuration is done
`timescale 1ns/1ps
`include "cmg_consts.vh"
module cmg_config_ctrl
(
    input  wire       clk_sys,
    input  wire       reset,
    input  wire       clk_en,
    input  wire       config_start,
    input  wire       mode_select_bit2,
    input  wire       mode_select_bit1,
    input  wire       mode_select_bit0,
    input  wire       config_pullup_select,
    input  wire       user_global_initialize,
    input  wire       user_global_output_float,
    input  wire       startup_alt_clk,
    input  wire       startup_alt_clk_sel,
    input  wire       host_clk,
    input  wire       host_valid,
    input  wire [7:0] host_data,
    input  wire       mem_data_serial,
    input  wire [7:0] mem_data_byte,
    input  wire [7:0] load_length,
    output reg        init_status,
    output wire       global_initialize,
    output wire       global_output_float,
    output reg  [2:0] mode_q,
    output reg        mode_valid_q,
    output reg        mode_illegal_q,
    output wire       mode_pins_user_io,
    output wire       borrowed_pins_user_io,
    output wire       pullup_enable,
    output reg        cfg_clk_out_q,
    output reg        cfg_clk_oe_n_q,
    output reg        addr_up_q,
    output reg  [7:0] cfg_byte_q,
    output reg        cfg_byte_valid_q,
    output reg        chain_out_q,
    output reg        config_done_q
);
    wire       m2_s;
    wire       m1_s;
    wire       m0_s;
    wire       hclk_s;
    wire       hval_s;
    wire       alt_s;
    reg  [2:0] st_q;
    reg  [7:0] cnt_q;
    reg  [3:0] div_q;
    reg  [2:0] bit_q;
    reg  [7:0] shift_q;
    reg  [7:0] count_q;
    reg  [2:0] step_q;
    reg        hclk_q;
    reg        alt_q;
    reg        self_q;
    reg        serial_q;
    wire       take;
    wire       step_tick;
    wire [7:0] nxt_shift;

    // mode, host clock, host valid and alternate clock pins pass two flops before use
    cmg_sync2 u_m2 (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
                    .pin_in(mode_select_bit2), .sync_out(m2_s));
    cmg_sync2 u_m1 (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
                    .pin_in(mode_select_bit1), .sync_out(m1_s));
    cmg_sync2 u_m0 (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
                    .pin_in(mode_select_bit0), .sync_out(m0_s));
    cmg_sync2 u_hc (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
                    .pin_in(host_clk), .sync_out(hclk_s));
    cmg_sync2 u_hv (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
                    .pin_in(host_valid), .sync_out(hval_s));
    cmg_sync2 u_ac (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
                    .pin_in(startup_alt_clk), .sync_out(alt_s));

    // global controls: internal configuration plus user request
    assign global_initialize = (st_q != `CMG_ST_DONE) || user_global_initialize;
    assign global_output_float = (st_q != `CMG_ST_DONE) || user_global_output_float;
    assign mode_pins_user_io = config_done_q;
    assign borrowed_pins_user_io = config_done_q;
    assign pullup_enable = ~config_pullup_select && (st_q != `CMG_ST_DONE);

    // a data beat: own clock edge in self modes, rising host clock otherwise
    assign take = (st_q == `CMG_ST_LOAD) &&
                  (self_q ? (div_q == `CMG_CCLK_DIV - 4'h1 && cfg_clk_out_q)
                          : (hclk_s && !hclk_q && hval_s));
    assign step_tick = startup_alt_clk_sel ? (alt_s && !alt_q) : 1'b1;
    assign nxt_shift = self_q ? {shift_q[6:0], mem_data_serial}
                              : {shift_q[6:0], host_data[0]};

    // edge history for the host and alternate clocks
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            hclk_q <= 1'b0;
            alt_q  <= 1'b0;
        end
        else if (clk_en)
        begin
            hclk_q <= hclk_s;
            alt_q  <= alt_s;
        end
    end

    // configuration sequencer
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            st_q             <= `CMG_ST_IDLE;
            cnt_q            <= 8'h00;
            div_q            <= 4'h0;
            bit_q            <= 3'h0;
            shift_q          <= 8'h00;
            count_q          <= 8'h00;
            step_q           <= 3'h0;
            init_status      <= 1'b0;
            mode_q           <= 3'h0;
            mode_valid_q     <= 1'b0;
            mode_illegal_q   <= 1'b0;
            self_q           <= 1'b0;
            serial_q         <= 1'b0;
            cfg_clk_out_q    <= 1'b0;
            cfg_clk_oe_n_q   <= 1'b1;
            addr_up_q        <= 1'b1;
            cfg_byte_q       <= 8'h00;
            cfg_byte_valid_q <= 1'b0;
            chain_out_q      <= 1'b0;
            config_done_q    <= 1'b0;
        end
        else if (clk_en)
        begin
            cfg_byte_valid_q <= 1'b0;
            case (st_q)
                `CMG_ST_IDLE:
                begin
                    if (config_start)
                    begin
                        st_q          <= `CMG_ST_INIT;
                        cnt_q         <= 8'h00;
                        config_done_q <= 1'b0;
                    end
                end
                `CMG_ST_INIT:
                begin
                    // memory clear time before init status rises
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == `CMG_INIT_CYCLES)
                    begin
                        init_status    <= 1'b1;
                        mode_q         <= {m2_s, m1_s, m0_s};
                        mode_valid_q   <= 1'b1;
                        mode_illegal_q <= ({m2_s, m1_s, m0_s} == `CMG_MODE_ILLEGAL);
                        self_q         <= ~m2_s;
                        serial_q       <= ~m2_s ? ~m1_s : m0_s;
                        addr_up_q      <= ~({m2_s, m1_s, m0_s} == `CMG_MODE_PAR_DOWN);
                        cfg_clk_oe_n_q <= m2_s;
                        div_q          <= 4'h0;
                        bit_q          <= 3'h0;
                        count_q        <= 8'h00;
                        st_q           <= ({m2_s, m1_s, m0_s} == `CMG_MODE_ILLEGAL) ?
                                          `CMG_ST_IDLE : `CMG_ST_LOAD;
                    end
                end
                `CMG_ST_LOAD:
                begin
                    // self modes divide the system clock into the config clock
                    if (self_q)
                    begin
                        if (div_q == `CMG_CCLK_DIV - 4'h1)
                        begin
                            div_q         <= 4'h0;
                            cfg_clk_out_q <= ~cfg_clk_out_q;
                        end
                        else
                            div_q <= div_q + 4'h1;
                    end
                    if (take)
                    begin
                        if (serial_q)
                        begin
                            shift_q     <= nxt_shift;
                            chain_out_q <= shift_q[7];
                            bit_q       <= bit_q + 3'h1;
                            if (bit_q == 3'h7)
                            begin
                                cfg_byte_q       <= nxt_shift;
                                cfg_byte_valid_q <= 1'b1;
                                count_q          <= count_q + 8'h01;
                            end
                        end
                        else
                        begin
                            // byte-wide path, downstream chain gets the last byte's msb
                            cfg_byte_q       <= self_q ? mem_data_byte : host_data;
                            cfg_byte_valid_q <= 1'b1;
                            chain_out_q      <= cfg_byte_q[7];
                            count_q          <= count_q + 8'h01;
                        end
                    end
                    if (count_q == load_length && count_q != 8'h00)
                    begin
                        st_q           <= `CMG_ST_STARTUP;
                        step_q         <= 3'h0;
                        cfg_clk_out_q  <= 1'b0;
                        cfg_clk_oe_n_q <= 1'b1;
                    end
                end
                `CMG_ST_STARTUP:
                begin
                    // start-up steps may be paced by the alternate clock
                    if (step_tick)
                    begin
                        step_q <= step_q + 3'h1;
                        if (step_q == `CMG_STARTUP_STEPS - 3'h1)
                        begin
                            st_q          <= `CMG_ST_DONE;
                            config_done_q <= 1'b1;
                        end
                    end
                end
                `CMG_ST_DONE:
                begin
                    // new configuration only on request; mode stays latched
                    if (config_start)
                    begin
                        st_q          <= `CMG_ST_INIT;
                        cnt_q         <= 8'h00;
                        init_status   <= 1'b0;
                        mode_valid_q  <= 1'b0;
                        config_done_q <= 1'b0;
                    end
                end
                default:
                    st_q <= `CMG_ST_IDLE;
            endcase
        end
    end
endmodule

// ==== sim/cmg_cfg_asserts.sv ====
// port checker for the configuration controller
`timescale 1ns/1ps
module cmg_cfg_asserts
(
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic       user_global_initialize,
    input wire logic       user_global_output_float,
    input wire logic       config_pullup_select,
    input wire logic       init_status,
    input wire logic       global_initialize,
    input wire logic       global_output_float,
    input wire logic [2:0] mode_q,
    input wire logic       mode_valid_q,
    input wire logic       mode_illegal_q,
    input wire logic       mode_pins_user_io,
    input wire logic       borrowed_pins_user_io,
    input wire logic       pullup_enable,
    input wire logic       cfg_clk_oe_n_q,
    input wire logic       addr_up_q,
    input wire logic       cfg_byte_valid_q,
    input wire logic       config_done_q
);
    // one clock domain, so clocking and disable are declared once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // a byte strobe is a single cycle wide
    sequence s_pulse;
        cfg_byte_valid_q ##1 !cfg_byte_valid_q;
    endsequence
    a_init_held: assert property (!config_done_q |-> global_initialize)
        else $error("init dropped during configuration");
    a_init_user: assert property (user_global_initialize |-> global_initialize)
        else $error("user init request lost");
    a_float_held: assert property (!config_done_q |-> global_output_float)
        else $error("outputs released before done");
    a_float_user: assert property (user_global_output_float |-> global_output_float)
        else $error("user float request lost");
    a_pins_free: assert property (mode_pins_user_io == config_done_q
        && borrowed_pins_user_io == config_done_q)
        else $error("pin release not tied to done");
    a_pullup_on: assert property (!config_pullup_select && !config_done_q |-> pullup_enable)
        else $error("pull-ups off during configuration");
    a_mode_hold: assert property ($changed(mode_q) |-> init_status || mode_illegal_q)
        else $error("mode changed outside sampling");
    a_dir_down: assert property (mode_valid_q |-> addr_up_q == (mode_q != 3'h3))
        else $error("address direction wrong");
    a_self_clock: assert property (!cfg_clk_oe_n_q |-> mode_q < 3'h4)
        else $error("clock driven in host mode");
    a_byte_pulse: assert property (cfg_byte_valid_q |-> s_pulse)
        else $error("byte strobe too long");
endmodule

// ==== sim/cmg_cfg_partner.sv ====
// memory or host model feeding configuration bytes
`timescale 1ns/1ps
module cmg_cfg_partner
(
    input  wire       clk_sys,
    input  wire       run,
    input  wire       host_mode,
    input  wire       ser,
    input  wire       cfg_clk_out_q,
    output reg        mem_data_serial,
    output reg  [7:0] mem_data_byte,
    output reg        host_clk,
    output reg        host_valid,
    output reg  [7:0] host_data
);
    reg  [15:0] beat = 16'h0;
    reg  [1:0]  div = 2'h0;
    reg         clk_d = 1'b0;
    wire [15:0] idx = ser ? (beat >> 3) : beat;
    wire [7:0]  cur = idx[7:0] * 8'h1d + 8'h3c;
    wire        bit_v = cur[3'h7 - beat[2:0]];
    // bits go msb first; idle data lines flip every cycle so stale data never matches
    always @(posedge clk_sys)
    begin
        clk_d <= cfg_clk_out_q;
        if (!run)
        begin
            {beat, div, host_clk, host_valid} <= 20'h0;
            {host_data, mem_data_byte} <= ~{host_data, mem_data_byte};
            mem_data_serial <= ~mem_data_serial;
        end
        else
        begin
            div <= div + 2'h1;
            if (host_mode && div == 2'h3)
                host_clk <= ~host_clk;
            if ((host_mode && div == 2'h3 && host_clk) || (!host_mode && clk_d && !cfg_clk_out_q))
                beat <= beat + 16'h1;
            host_valid <= host_mode;
            host_data <= ser ? {7'h0, bit_v} : cur;
            mem_data_serial <= bit_v;
            mem_data_byte <= cur;
        end
    end
endmodule

// ==== sim/tb_cmg_config_ctrl.sv ====
// bench for the configuration controller
`timescale 1ns/1ps
module tb_cmg_config_ctrl;
    reg        clk_sys = 0, reset = 1, config_start = 0, startup_alt_clk = 0;
    reg        mode_select_bit2 = 0, mode_select_bit1 = 0, mode_select_bit0 = 0;
    reg        config_pullup_select = 0, startup_alt_clk_sel = 0;
    reg        user_global_initialize = 0, user_global_output_float = 0;
    reg  [7:0] load_length = 8'h1;
    integer    err_count = 0, num_checks = 0, seed = 32'h7929, nbytes = 0, code = 0;
    wire       host_clk, host_valid, mem_data_serial, init_status, global_initialize;
    wire       global_output_float, mode_valid_q, mode_illegal_q, mode_pins_user_io;
    wire       borrowed_pins_user_io, pullup_enable, cfg_clk_out_q, cfg_clk_oe_n_q;
    wire       addr_up_q, cfg_byte_valid_q, config_done_q, chain_out_q;
    reg  [7:0] prev_b;
    wire [7:0] host_data, mem_data_byte, cfg_byte_q;
    wire [2:0] mode_q;
    wire       run = init_status & ~config_done_q & ~mode_illegal_q;
    // free-running clocks; the alternate one is unrelated in phase
    always #5 clk_sys = ~clk_sys;
    always #23 startup_alt_clk = ~startup_alt_clk;
    cmg_config_ctrl u_cmg_config_ctrl (.clk_sys, .reset, .clk_en(1'b1), .config_start,
        .mode_select_bit2, .mode_select_bit1, .mode_select_bit0, .config_pullup_select,
        .user_global_initialize, .user_global_output_float, .startup_alt_clk,
        .startup_alt_clk_sel, .host_clk, .host_valid, .host_data, .mem_data_serial,
        .mem_data_byte, .load_length, .init_status, .global_initialize, .global_output_float,
        .mode_q, .mode_valid_q, .mode_illegal_q, .mode_pins_user_io, .borrowed_pins_user_io,
        .pullup_enable, .cfg_clk_out_q, .cfg_clk_oe_n_q, .addr_up_q, .cfg_byte_q,
        .cfg_byte_valid_q, .chain_out_q, .config_done_q);
    cmg_cfg_partner u_cmg_cfg_partner (.clk_sys, .run, .host_mode(code >= 6),
        .ser(code < 2 || code == 7), .cfg_clk_out_q, .mem_data_serial, .mem_data_byte,
        .host_clk, .host_valid, .host_data);
    task chk(input [7:0] got, input [7:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    end
    endtask
    task wrap_up;
    begin
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    // bounded wait: sel 0 for init status, 1 for done
    task wait_hi(input sel);
        integer n;
    begin
        n = 0;
        while ((sel ? config_done_q : init_status) !== 1'b1 && n < 5000)
        begin
            @(posedge clk_sys);
            #1;
            n = n + 1;
        end
        if (n == 5000)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED at %0t: wait ran out", $time);
            wrap_up;
        end
    end
    endtask
    // model: byte n of the stream is n*1d+3c in every loading mode
    always @(posedge clk_sys)
        if (cfg_byte_valid_q === 1'b1)
        begin
            chk(cfg_byte_q, nbytes * 8'h1d + 8'h3c);
            // chain carries what the previous byte pushed out: lsb serially, msb byte-wide
            prev_b = (nbytes - 1) * 8'h1d + 8'h3c;
            if (nbytes > 0)
                chk(chain_out_q, (code < 2 || code == 7) ? prev_b[0] : prev_b[7]);
            nbytes = nbytes + 1;
        end
    // every mode code, random pull-up select and length
    initial
    begin
        repeat (2) @(posedge clk_sys);
        #1 reset = 0;
        for (code = 0; code < 8; code = code + 1)
        begin
            {mode_select_bit2, mode_select_bit1, mode_select_bit0} = code;
            config_pullup_select = $random(seed);
            startup_alt_clk_sel = (code == 7);
            load_length = ($random(seed) & 3) + 1;
            nbytes = 0;
            config_start = 1;
            @(posedge clk_sys);
            #1 config_start = 0;
            wait_hi(0);
            {mode_select_bit2, mode_select_bit1, mode_select_bit0} = ~code;
            chk(mode_q, code);
            chk(mode_illegal_q, code == 4);
            chk(pullup_enable, !config_pullup_select);
            chk({global_initialize, global_output_float}, 8'h3);
            if (code == 4 || code == 5)
            begin
                reset = 1;
                @(posedge clk_sys);
                #1 reset = 0;
            end
            else
            begin
                wait_hi(1);
                chk(nbytes, load_length);
                chk(mode_q, code);
                chk({mode_pins_user_io, borrowed_pins_user_io}, 8'h3);
                chk(addr_up_q, code != 3);
                chk({global_initialize, global_output_float}, 8'h0);
                {user_global_initialize, user_global_output_float} = 2'h3;
                #1 chk({global_initialize, global_output_float}, 8'h3);
                {user_global_initialize, user_global_output_float} = 2'h0;
            end
        end
        wrap_up;
    end
endmodule
bind cmg_config_ctrl cmg_cfg_asserts u_cmg_cfg_asserts (.clk_sys, .reset,
    .user_global_initialize, .user_global_output_float, .config_pullup_select, .init_status,
    .global_initialize, .global_output_float, .mode_q, .mode_valid_q, .mode_illegal_q,
    .mode_pins_user_io, .borrowed_pins_user_io, .pullup_enable, .cfg_clk_oe_n_q,
    .addr_up_q, .cfg_byte_valid_q, .config_done_q);
